// ==== logic/lvr_ctrl.sv ====
// Supply monitor control: options, hysteresis, reset request, status
//
// The register offsets and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module lvr_ctrl (
    input  wire logic                        clk,
    input  wire logic                        reset_n,
    // Avalon-MM slave
    input  wire logic [lvr_pkg::AVS_AW-1:0]  avs_address,
    input  wire logic                        avs_read,
    input  wire logic                        avs_write,
    input  wire logic [lvr_pkg::AVS_DW-1:0]  avs_writedata,
    input  wire logic [3:0]                  avs_byteenable,
    output var  logic [lvr_pkg::AVS_DW-1:0]  avs_readdata,
    output var  logic                        avs_waitrequest,
    // Analog comparator, asynchronous
    input  wire logic                        cmp_fall_3v,
    input  wire logic                        cmp_rise_3v,
    input  wire logic                        cmp_fall_5v,
    input  wire logic                        cmp_rise_5v,
    // Low power state from the system
    input  wire logic                        stop_mode,
    // To the analog monitor and the system reset logic
    output var  logic                        monitor_on,
    output var  logic                        trip_range_select,
    output var  logic                        lv_reset_req
);

    // --------------------------------------------------------------
    // Declarations
    // --------------------------------------------------------------
    logic [lvr_pkg::CMP_W-1:0]   cmp_async;
    logic [lvr_pkg::CMP_W-1:0]   cmp_sync;
    logic                        below_sel;
    logic                        above_sel;
    logic                        supply_low_flag;
    logic                        active;
    logic                        resets_on;
    logic                        trigger;
    logic                        listen;

    logic                        bus_req;
    logic                        accept;
    logic                        hit_opt;
    logic                        hit_stat;

    logic [lvr_pkg::OPT_W-1:0]   option_word_one_q;
    logic [lvr_pkg::OPT_W-1:0]   option_word_one_d;
    logic                        range_up_q;
    logic                        range_up_d;
    logic                        wait_q;
    logic                        wait_d;
    logic [lvr_pkg::AVS_DW-1:0]  rdata_q;
    logic [lvr_pkg::AVS_DW-1:0]  rdata_d;
    logic [lvr_pkg::STAT_W-1:0]  low_voltage_status;

    lvr_pkg::lvr_state_e         state_q;
    lvr_pkg::lvr_state_e         state_d;
    logic                        mon_on_q;
    logic                        mon_on_d;
    logic                        range_q;
    logic                        range_d;
    logic                        req_q;
    logic                        req_d;
    logic                        on_d1_q;
    logic                        on_d1_d;
    logic                        on_d2_q;
    logic                        on_d2_d;

    // --------------------------------------------------------------
    // Comparator synchronisation
    // --------------------------------------------------------------
    assign cmp_async[lvr_pkg::CMP_FALL3_I] = cmp_fall_3v;
    assign cmp_async[lvr_pkg::CMP_RISE3_I] = cmp_rise_3v;
    assign cmp_async[lvr_pkg::CMP_FALL5_I] = cmp_fall_5v;
    assign cmp_async[lvr_pkg::CMP_RISE5_I] = cmp_rise_5v;

    // Comparator outputs move with the supply, not with clk
    lvr_sync #(
        .WIDTH    (lvr_pkg::CMP_W)
    ) u_sync (
        .clk      (clk),
        .reset_n  (reset_n),
        .async_in (cmp_async),
        .sync_out (cmp_sync)
    );

    // --------------------------------------------------------------
    // Monitor gating and threshold selection
    // --------------------------------------------------------------
    always_comb begin
        // Wait mode does not gate the monitor, only stop mode does
        active = !option_word_one_q[lvr_pkg::OPT_PWR_DIS_BIT]
               && (!stop_mode
                   || option_word_one_q[lvr_pkg::OPT_STOP_EN_BIT]);
        resets_on = !option_word_one_q[lvr_pkg::OPT_RST_DIS_BIT];
        if (option_word_one_q[lvr_pkg::OPT_RANGE_BIT]) begin
            below_sel = cmp_sync[lvr_pkg::CMP_FALL5_I];
            above_sel = cmp_sync[lvr_pkg::CMP_RISE5_I];
        end else begin
            below_sel = cmp_sync[lvr_pkg::CMP_FALL3_I];
            above_sel = cmp_sync[lvr_pkg::CMP_RISE3_I];
        end
        // A monitor just powered up is heard only once the synchroniser
        // holds answers given while it was powered; earlier ones are junk
        listen = active && mon_on_q && on_d1_q && on_d2_q;
        // A fresh 5 V selection trips unless already above rising level
        trigger = listen && resets_on
                && (below_sel
                    || (range_up_q && !above_sel));
    end

    // --------------------------------------------------------------
    // Status flag with hysteresis
    // --------------------------------------------------------------
    // Flag follows the comparator whether or not resets are enabled
    lvr_hyst u_hyst (
        .clk             (clk),
        .reset_n         (reset_n),
        .enable          (listen),
        .below_fall      (below_sel),
        .above_rise      (above_sel),
        .supply_low_flag (supply_low_flag)
    );

    always_comb begin
        low_voltage_status = lvr_pkg::STAT_RESET;
        low_voltage_status[lvr_pkg::STAT_FLAG_BIT] = supply_low_flag;
    end

    // --------------------------------------------------------------
    // Reset request state machine
    // --------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            lvr_pkg::LVR_RUN: begin
                if (trigger) begin
                    state_d = lvr_pkg::LVR_HELD;
                end
            end
            lvr_pkg::LVR_HELD: begin
                // Falling level alone is not enough to let go
                if (listen && above_sel) begin
                    state_d = lvr_pkg::LVR_RUN;
                end
            end
            default: begin
                state_d = lvr_pkg::LVR_RUN;
            end
        endcase
        // Only a reset request leaves this block, never an interrupt
        req_d    = (state_d == lvr_pkg::LVR_HELD);
        mon_on_d = active;
        range_d  = option_word_one_q[lvr_pkg::OPT_RANGE_BIT];
        // Power history of the analog side, one step per sync flop
        on_d1_d  = mon_on_q;
        on_d2_d  = on_d1_q;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q  <= lvr_pkg::LVR_RUN;
            req_q    <= 1'b0;
            mon_on_q <= 1'b1;
            range_q  <= 1'b0;
            on_d1_q  <= 1'b1;
            on_d2_q  <= 1'b1;
        end else begin
            state_q  <= state_d;
            req_q    <= req_d;
            mon_on_q <= mon_on_d;
            range_q  <= range_d;
            on_d1_q  <= on_d1_d;
            on_d2_q  <= on_d2_d;
        end
    end

    // --------------------------------------------------------------
    // Avalon-MM slave
    // --------------------------------------------------------------
    // Every access takes one wait state: data are registered first
    always_comb begin
        bus_req  = avs_read || avs_write;
        accept   = bus_req && !wait_q;
        hit_opt  = (avs_address == lvr_pkg::OPT_OFS);
        hit_stat = (avs_address == lvr_pkg::STAT_OFS);
        wait_d   = !(bus_req && wait_q);
        rdata_d  = rdata_q;
        if (avs_read && wait_q) begin
            rdata_d = '0;
            if (hit_opt) begin
                rdata_d[lvr_pkg::OPT_W-1:0] = option_word_one_q;
            end else if (hit_stat) begin
                rdata_d[lvr_pkg::STAT_W-1:0] = low_voltage_status;
            end
        end
        option_word_one_d = option_word_one_q;
        // Status offset has no write path, so the flag is untouched
        if (avs_write && accept && hit_opt && avs_byteenable[0]) begin
            option_word_one_d =
                avs_writedata[lvr_pkg::OPT_W-1:0];
        end
        range_up_d = !option_word_one_q[lvr_pkg::OPT_RANGE_BIT]
                   && option_word_one_d[lvr_pkg::OPT_RANGE_BIT];
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            option_word_one_q <= lvr_pkg::OPT_RESET;
            range_up_q        <= 1'b0;
            wait_q            <= 1'b1;
            rdata_q           <= '0;
        end else begin
            option_word_one_q <= option_word_one_d;
            range_up_q        <= range_up_d;
            wait_q            <= wait_d;
            rdata_q           <= rdata_d;
        end
    end

    // --------------------------------------------------------------
    // Outputs
    // --------------------------------------------------------------
    assign avs_readdata      = rdata_q;
    assign avs_waitrequest   = wait_q;
    assign monitor_on        = mon_on_q;
    assign trip_range_select = range_q;
    assign lv_reset_req      = req_q;

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    logic first_q;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            first_q <= 1'b0;
        end else begin
            first_q <= 1'b1;
        end
    end

    opt_default_a:
    assert property (!first_q |-> option_word_one_q
                     == lvr_pkg::OPT_RESET && monitor_on)
    else $error("options not at default after reset");

    range_default_a:
    assert property (!first_q |-> !trip_range_select)
    else $error("range not 3 V after reset");

    pwr_gate_a:
    assert property (option_word_one_q[lvr_pkg::OPT_PWR_DIS_BIT]
                     |=> !monitor_on)
    else $error("monitor on while power disabled");

    stop_gate_a:
    assert property (stop_mode
                     && !option_word_one_q[lvr_pkg::OPT_STOP_EN_BIT]
                     |=> !monitor_on)
    else $error("monitor on in stop without stop enable");

    fall_trip_a:
    assert property (listen && resets_on && below_sel
                     |=> lv_reset_req)
    else $error("no reset on falling supply");

    rst_dis_a:
    assert property (!resets_on && !lv_reset_req
                     |=> !lv_reset_req)
    else $error("reset raised while resets disabled");

    range_sel_a:
    assert property (option_word_one_q[lvr_pkg::OPT_RANGE_BIT]
                     |=> trip_range_select)
    else $error("range output does not follow option");

    force_5v_a:
    assert property (range_up_q && listen && resets_on
                     && !cmp_sync[lvr_pkg::CMP_RISE5_I]
                     |=> lv_reset_req)
    else $error("no reset on 5 V select while low");

    hold_rise_a:
    assert property (lv_reset_req && !above_sel |=> lv_reset_req)
    else $error("reset released below rising level");

    status_read_a:
    assert property (avs_read && wait_q && hit_stat
                     |=> avs_readdata[lvr_pkg::STAT_FLAG_BIT]
                         == $past(supply_low_flag)
                     && !avs_waitrequest)
    else $error("status read does not show flag");

    wait_one_a:
    assert property (bus_req && avs_waitrequest |=> !avs_waitrequest
                     ##1 avs_waitrequest)
    else $error("wait state not exactly one cycle");

    warm_up_a:
    assert property (!(mon_on_q && on_d1_q && on_d2_q)
                     |=> $stable(supply_low_flag) && $stable(state_q))
    else $error("comparator heard before synchroniser flushed");

    warm_up_c:
    cover property (!on_d2_q ##1 listen);

    held_release_c:
    cover property (lv_reset_req ##[1:50] !lv_reset_req);

    range_up_c:
    cover property (range_up_q && !cmp_sync[lvr_pkg::CMP_RISE5_I]
                    ##1 lv_reset_req);

    polled_c:
    cover property (!resets_on && supply_low_flag);

    stop_active_c:
    cover property (stop_mode && monitor_on);

endmodule
`default_nettype wire

// ==== logic/lvr_hyst.sv ====
// Hysteresis latch for the supply low flag
`timescale 1ns/1ns
`default_nettype none
module lvr_hyst (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic enable,
    input  wire logic below_fall,
    input  wire logic above_rise,
    output var  logic supply_low_flag
);

    logic flag_q;
    logic flag_d;

    always_comb begin
        flag_d = flag_q;
        // Between the two levels the flag keeps its value
        if (enable && below_fall) begin
            flag_d = 1'b1;
        end else if (enable && above_rise) begin
            flag_d = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign supply_low_flag = flag_q;

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    flag_set_a:
    assert property (@(posedge clk) disable iff (!reset_n)
        enable && below_fall |=> supply_low_flag)
    else $error("flag not set below falling level");

    flag_keep_a:
    assert property (@(posedge clk) disable iff (!reset_n)
        !(enable && (below_fall || above_rise))
        |=> $stable(supply_low_flag))
    else $error("flag changed between levels");

endmodule
`default_nettype wire

// ==== logic/lvr_pkg.sv ====
// Constants and types shared by the supply monitor control block
package lvr_pkg;

    // --------------------------------------------------------------
    // Register bus
    // --------------------------------------------------------------
    localparam int unsigned AVS_AW = 4;
    localparam int unsigned AVS_DW = 32;
    localparam logic [AVS_AW-1:0] OPT_OFS  = 4'h0;
    localparam logic [AVS_AW-1:0] STAT_OFS = 4'h4;

    // --------------------------------------------------------------
    // Option word one fields
    // --------------------------------------------------------------
    localparam int unsigned OPT_W           = 4;
    localparam int unsigned OPT_STOP_EN_BIT = 0;
    localparam int unsigned OPT_PWR_DIS_BIT = 1;
    localparam int unsigned OPT_RANGE_BIT   = 2;
    localparam int unsigned OPT_RST_DIS_BIT = 3;
    // Monitor on, resets on, 3 V range, off in stop
    localparam logic [OPT_W-1:0] OPT_RESET  = 4'h0;

    // --------------------------------------------------------------
    // Low voltage status fields
    // --------------------------------------------------------------
    localparam int unsigned STAT_W        = 8;
    localparam int unsigned STAT_FLAG_BIT = 0;
    localparam logic [STAT_W-1:0] STAT_RESET = 8'h00;

    // --------------------------------------------------------------
    // Comparator lines, in synchroniser bit order
    // --------------------------------------------------------------
    localparam int unsigned CMP_W       = 4;
    localparam int unsigned CMP_FALL3_I = 0;
    localparam int unsigned CMP_RISE3_I = 1;
    localparam int unsigned CMP_FALL5_I = 2;
    localparam int unsigned CMP_RISE5_I = 3;

    typedef enum logic [0:0] {
        LVR_RUN  = 1'b0,
        LVR_HELD = 1'b1
    } lvr_state_e;

endpackage

// ==== logic/lvr_sync.sv ====
// Two-stage synchroniser for the asynchronous comparator outputs
`timescale 1ns/1ns
`default_nettype none
module lvr_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);

    // First stage feeds only the second stage
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            logic meta_q;
            logic sync_q;
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end else begin
                    meta_q <= async_in[gi];
                    sync_q <= meta_q;
                end
            end
            assign sync_out[gi] = sync_q;
        end
    endgenerate

endmodule
`default_nettype wire

// ==== verif/lvr_supply_model.sv ====
// Behavioural model of the analog supply comparator pair
`timescale 1ns/1ns
`default_nettype none
module lvr_supply_model #(
    // Trip levels in arbitrary supply units, plain defaults
    parameter logic [7:0] FALL3 = 8'h20,
    parameter logic [7:0] RISE3 = 8'h28,
    parameter logic [7:0] FALL5 = 8'h40,
    parameter logic [7:0] RISE5 = 8'h48
) (
    input  wire logic [7:0] level,
    input  wire logic       powered,
    output var  logic       cmp_fall_3v,
    output var  logic       cmp_rise_3v,
    output var  logic       cmp_fall_5v,
    output var  logic       cmp_rise_5v
);
    logic [3:0] raw;

    always_comb begin
        raw = {level > RISE5, level < FALL5, level > RISE3, level < FALL3};
        // Unpowered comparator gives no valid answer: show the opposite,
        // so a block that listens while off is caught
        if (!powered) begin
            raw = ~raw;
        end
        {cmp_rise_5v, cmp_fall_5v, cmp_rise_3v, cmp_fall_3v} = raw;
    end
endmodule
`default_nettype wire

// ==== verif/test_lvr_ctrl.sv ====
// Self-checking testbench for the supply monitor control block
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module test_lvr_ctrl;
    logic        clk, reset_n, avs_read, avs_write, stop_mode;
    logic [3:0]  avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, rdq;
    logic        avs_waitrequest, monitor_on, trip_range_select;
    logic        lv_reset_req, c_f3, c_r3, c_f5, c_r5;
    logic [7:0]  supply_lvl;
    int          n_errors, comparisons;
    // --------------------------------------------------------------
    // Design, comparator model, clock
    // --------------------------------------------------------------
    lvr_ctrl uut (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .cmp_fall_3v(c_f3), .cmp_rise_3v(c_r3), .cmp_fall_5v(c_f5),
        .cmp_rise_5v(c_r5), .stop_mode(stop_mode), .monitor_on(monitor_on),
        .trip_range_select(trip_range_select), .lv_reset_req(lv_reset_req));
    lvr_supply_model cmp (.level(supply_lvl), .powered(monitor_on),
        .cmp_fall_3v(c_f3), .cmp_rise_3v(c_r3), .cmp_fall_5v(c_f5),
        .cmp_rise_5v(c_r5));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // --------------------------------------------------------------
    // Tasks
    // --------------------------------------------------------------
    task automatic give_verdict;
        if (n_errors == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Request held until the rising edge where waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge clk);
        avs_address    <= a;
        avs_read       <= !w;
        avs_write      <= w;
        avs_writedata  <= d;
        avs_byteenable <= be;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (avs_waitrequest !== 1'b0) begin
            $display("ERROR %0t: bus answer timed out", $time);
            n_errors++;
            give_verdict;
        end
        rdq = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, 4'hf);
        `CHK(rdq, e)
    endtask
    task automatic lv(input logic [7:0] v);
        @(posedge clk);
        supply_lvl <= v;
    endtask
    // Waits n edges, then lets the outputs settle before checking
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic do_reset;
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        @(negedge clk);
    endtask
    // --------------------------------------------------------------
    // Sequence; levels: 10 low, 24 in 3 V band, 30 ok for 3 V only,
    // 44 in 5 V band, 50 ok for 5 V
    // --------------------------------------------------------------
    initial begin
        n_errors = 0;
        comparisons = 0;
        reset_n = 1'b0;
        {avs_read, avs_write, stop_mode} = 3'h0;
        avs_address = 4'h0;
        avs_byteenable = 4'hf;
        avs_writedata = 32'h0;
        supply_lvl = 8'h30;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        wt(0);
        `CHK(monitor_on, 1'b1)
        `CHK(trip_range_select, 1'b0)
        `CHK(lv_reset_req, 1'b0)
        rd_chk(lvr_pkg::OPT_OFS, 32'h0);
        rd_chk(lvr_pkg::STAT_OFS, 32'h0);
        lv(8'h10);
        wt(2);
        `CHK(lv_reset_req, 1'b0)
        wt(1);
        `CHK(lv_reset_req, 1'b1)
        rd_chk(lvr_pkg::STAT_OFS, 32'h1);
        wr(lvr_pkg::STAT_OFS, 32'h0);
        rd_chk(lvr_pkg::STAT_OFS, 32'h1);
        lv(8'h24);
        wt(4);
        `CHK(lv_reset_req, 1'b1)
        rd_chk(lvr_pkg::STAT_OFS, 32'h1);
        lv(8'h30);
        wt(4);
        `CHK(lv_reset_req, 1'b0)
        rd_chk(lvr_pkg::STAT_OFS, 32'h0);
        lv(8'h10);
        wt(4);
        do_reset;
        `CHK(lv_reset_req, 1'b0)
        lv(8'h30);
        wt(4);
        bus(1'b1, lvr_pkg::OPT_OFS, 32'hf, 4'h0);
        rd_chk(lvr_pkg::OPT_OFS, 32'h0);
        wr(4'h8, 32'hf);
        rd_chk(4'h8, 32'h0);
        // Resets off: flag still follows the supply
        wr(lvr_pkg::OPT_OFS, 32'h8);
        lv(8'h10);
        wt(4);
        `CHK(lv_reset_req, 1'b0)
        rd_chk(lvr_pkg::STAT_OFS, 32'h1);
        lv(8'h30);
        wt(4);
        rd_chk(lvr_pkg::STAT_OFS, 32'h0);
        wr(lvr_pkg::OPT_OFS, 32'h2);
        wt(1);
        `CHK(monitor_on, 1'b0)
        // In-band level: an unpowered comparator shows both lines high
        lv(8'h24);
        wt(4);
        `CHK(lv_reset_req, 1'b0)
        rd_chk(lvr_pkg::STAT_OFS, 32'h0);
        lv(8'h30);
        wr(lvr_pkg::OPT_OFS, 32'h0);
        wt(2);
        `CHK(lv_reset_req, 1'b0)
        rd_chk(lvr_pkg::STAT_OFS, 32'h0);
        `CHK(monitor_on, 1'b1)
        // Stop mode, first without then with the stop enable
        @(posedge clk);
        stop_mode <= 1'b1;
        wt(1);
        `CHK(monitor_on, 1'b0)
        lv(8'h24);
        wt(4);
        `CHK(lv_reset_req, 1'b0)
        rd_chk(lvr_pkg::STAT_OFS, 32'h0);
        lv(8'h30);
        wt(4);
        wr(lvr_pkg::OPT_OFS, 32'h1);
        wt(1);
        `CHK(monitor_on, 1'b1)
        lv(8'h10);
        wt(4);
        `CHK(lv_reset_req, 1'b1)
        lv(8'h30);
        wt(4);
        `CHK(lv_reset_req, 1'b0)
        @(posedge clk);
        stop_mode <= 1'b0;
        // Supply inside the 5 V band, so only the range switch can trip
        lv(8'h44);
        wr(lvr_pkg::OPT_OFS, 32'h0);
        wr(lvr_pkg::OPT_OFS, 32'h4);
        wt(1);
        `CHK(trip_range_select, 1'b1)
        wt(3);
        `CHK(lv_reset_req, 1'b1)
        lv(8'h44);
        wt(4);
        `CHK(lv_reset_req, 1'b1)
        lv(8'h50);
        wt(4);
        `CHK(lv_reset_req, 1'b0)
        lv(8'h44);
        wt(4);
        rd_chk(lvr_pkg::STAT_OFS, 32'h0);
        lv(8'h30);
        wt(4);
        `CHK(lv_reset_req, 1'b1)
        rd_chk(lvr_pkg::OPT_OFS, 32'h4);
        give_verdict;
    end
endmodule
`default_nettype wire
